// File: rtl/uart_pkg.sv
// package: register map, field layout, modes and event carrier of the serial port
package uart_pkg;

  // ----------------------------------------
  // bus and register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam int APB_ADDR_W = 12;
  localparam int APB_DATA_W = 32;
  localparam logic [7:0] IDX_SERIAL_CTRL = 8'h00;
  localparam logic [7:0] IDX_POWER_CTRL = 8'h01;
  localparam logic [7:0] IDX_RX_DATA = 8'h02;
  localparam logic [7:0] IDX_TX_DATA = 8'h03;
  localparam logic [7:0] IDX_RX_DIV = 8'h04;
  localparam logic [7:0] IDX_TX_DIV = 8'h05;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h06;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h07;
  localparam logic [7:0] IDX_NODE_ADDR = 8'hA9;
  localparam logic [7:0] IDX_NODE_MASK = 8'hB9;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_MULTIPROC = 2;
  localparam int CTL_RX_EN = 3;
  localparam int CTL_TX_NINTH = 4;
  localparam int CTL_RX_NINTH = 5;
  localparam int CTL_RX_FLAG = 6;
  localparam int CTL_FE_FLAG = 7;
  localparam int CTL_TX_BUSY = 8;
  localparam int PWR_FE_EN = 0;
  localparam int IRQ_RX = 0;
  localparam int IRQ_FE = 1;
  localparam int IRQ_TX = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------
  // reset values and widths
  // ----------------------------------------
  localparam int DIV_W = 16;
  localparam logic [15:0] DIV_RESET = 16'h015B;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_SYNC = 2'h0,
    MODE_ASYNC8 = 2'h1,
    MODE_ASYNC9A = 2'h2,
    MODE_ASYNC9B = 2'h3
  } serial_mode_t;

  typedef enum logic [3:0] {
    RXS_IDLE = 4'h1,
    RXS_START = 4'h2,
    RXS_DATA = 4'h4,
    RXS_STOP = 4'h8
  } rx_state_t;

  typedef struct packed {
    logic dataDone;
    logic stopDone;
    logic stopValid;
    logic ninth;
    logic [7:0] data;
  } rx_event_t;

endpackage

// File: rtl/uart_addr_match.sv
// address comparator: given and broadcast address match
`timescale 1ns/1ps
`default_nettype none
module uart_addr_match
  import uart_pkg::*;
(
  input wire logic [7:0] nodeAddr,
  input wire logic [7:0] nodeMask,
  input wire logic [7:0] rxAddr,
  output logic givenHit,
  output logic bcastHit,
  output logic match
);
  logic [7:0] bcast;

  assign bcast = nodeAddr | nodeMask;
  assign givenHit = ((rxAddr ^ nodeAddr) & nodeMask) == 8'h00;
  assign bcastHit = ((rxAddr ^ bcast) & bcast) == 8'h00;
  assign match = givenHit | bcastHit;
endmodule
`default_nettype wire

// File: rtl/uart_rx_frame.sv
// receive framer: start check, data shifting, stop sampling
`timescale 1ns/1ps
`default_nettype none
module uart_rx_frame
  import uart_pkg::*;
#(
  parameter int DW = DIV_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rxLine,
  input wire logic enable,
  input wire logic nineBits,
  input wire logic [DW-1:0] bitDiv,
  output rx_event_t rxEvent,
  output logic busy
);
  rx_state_t state_reg;
  logic [DW-1:0] cnt_reg;
  logic [3:0] idx_reg;
  logic [8:0] bits_reg;
  logic [8:0] bits_next;
  logic rxLast_reg;
  rx_event_t event_reg;
  logic [3:0] lastIdx;
  logic tick;

  assign lastIdx = nineBits ? 4'h8 : 4'h7;
  assign tick = cnt_reg == '0;
  assign rxEvent = event_reg;
  assign busy = state_reg != RXS_IDLE;

  always_comb begin
    bits_next = bits_reg;
    bits_next[idx_reg] = rxLine;
  end

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= RXS_IDLE;
      cnt_reg <= '0;
      idx_reg <= 4'h0;
      bits_reg <= 9'h000;
      rxLast_reg <= 1'b1;
    end else begin
      rxLast_reg <= rxLine;
      if (!enable) begin
        state_reg <= RXS_IDLE;
      end else begin
        case (state_reg)
          RXS_IDLE: begin
            if (rxLast_reg && !rxLine) begin
              state_reg <= RXS_START;
              cnt_reg <= bitDiv >> 1;
            end
          end
          RXS_START: begin
            if (!tick) begin
              cnt_reg <= cnt_reg - 1'b1;
            end else if (!rxLine) begin
              state_reg <= RXS_DATA;
              cnt_reg <= bitDiv - 1'b1;
              idx_reg <= 4'h0;
            end else begin
              state_reg <= RXS_IDLE;
            end
          end
          RXS_DATA: begin
            if (!tick) begin
              cnt_reg <= cnt_reg - 1'b1;
            end else begin
              bits_reg <= bits_next;
              cnt_reg <= bitDiv - 1'b1;
              if (idx_reg == lastIdx) begin
                state_reg <= RXS_STOP;
              end else begin
                idx_reg <= idx_reg + 1'b1;
              end
            end
          end
          RXS_STOP: begin
            if (!tick) begin
              cnt_reg <= cnt_reg - 1'b1;
            end else begin
              state_reg <= RXS_IDLE;
            end
          end
          default: begin
            state_reg <= RXS_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // frame events
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      event_reg <= '0;
    end else begin
      event_reg.dataDone <= 1'b0;
      event_reg.stopDone <= 1'b0;
      if (enable && state_reg == RXS_DATA && tick && idx_reg == lastIdx) begin
        event_reg.dataDone <= 1'b1;
        event_reg.data <= bits_next[7:0];
        event_reg.ninth <= nineBits ? bits_next[8] : 1'b0;
      end
      if (enable && state_reg == RXS_STOP && tick) begin
        event_reg.stopDone <= 1'b1;
        event_reg.stopValid <= rxLine;
        if (!nineBits) begin
          event_reg.ninth <= rxLine;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/uart_frame_check_addr_match.sv
// serial port with stop-bit checking and address recognition, APB registers
// ----------------------------------------
// ----------------------------------------
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uart_frame_check_addr_match
  import uart_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [APB_DATA_W-1:0] pwdata,
  output logic [APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxLine,
  output logic txLine,
  output logic irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic rxMeta_reg;
  logic rxSync_reg;
  serial_mode_t mode_reg;
  logic multiproc_reg;
  logic rxEnable_reg;
  logic txNinth_reg;
  logic rxFlag_reg;
  logic frameErr_reg;
  logic frameErrEnable_reg;
  logic [7:0] rxData_reg;
  logic rxNinth_reg;
  logic [DIV_W-1:0] rxDiv_reg;
  logic [DIV_W-1:0] txDiv_reg;
  logic [7:0] nodeAddr_reg;
  logic [7:0] nodeMask_reg;
  logic [IRQ_W-1:0] irqStat_reg;
  logic [IRQ_W-1:0] irqMask_reg;
  logic irq_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [APB_DATA_W-1:0] prdata_reg;
  logic txBusy_reg;
  logic txLine_reg;
  logic [9:0] txShift_reg;
  logic [3:0] txLeft_reg;
  logic [DIV_W-1:0] txCnt_reg;
  logic txDone_reg;

  rx_event_t rxEv;
  logic rxBusy;
  logic givenHit;
  logic bcastHit;
  logic matchOk;
  logic asyncMode;
  logic addrOn;
  logic atStop;
  logic decide;
  logic accept;
  logic riSet;
  logic feSet;
  logic [7:0] regIdx;
  logic hit;
  logic access;
  logic wrDone;
  logic rdDone;
  logic [APB_DATA_W-1:0] readMux;
  logic txStart;
  logic txBitEnd;

  // ----------------------------------------
  // line synchroniser and receive framer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rxMeta_reg <= 1'b1;
      rxSync_reg <= 1'b1;
    end else begin
      rxMeta_reg <= rxLine;
      rxSync_reg <= rxMeta_reg;
    end
  end

  assign asyncMode = mode_reg != MODE_SYNC;

  uart_rx_frame #(.DW(DIV_W)) rxFramer (
    .clk(clk),
    .rst(rst),
    .rxLine(rxSync_reg),
    .enable(rxEnable_reg && asyncMode),
    .nineBits(mode_reg == MODE_ASYNC9A || mode_reg == MODE_ASYNC9B),
    .bitDiv(rxDiv_reg),
    .rxEvent(rxEv),
    .busy(rxBusy)
  );

  uart_addr_match addrMatch (
    .nodeAddr(nodeAddr_reg),
    .nodeMask(nodeMask_reg),
    .rxAddr(rxEv.data),
    .givenHit(givenHit),
    .bcastHit(bcastHit),
    .match(matchOk)
  );

  // ----------------------------------------
  // receive decision
  // ----------------------------------------
  assign addrOn = multiproc_reg && asyncMode;
  assign atStop = frameErrEnable_reg || (addrOn && mode_reg == MODE_ASYNC8);
  assign decide = atStop ? rxEv.stopDone : rxEv.dataDone;

  always_comb begin
    if (!addrOn) begin
      accept = 1'b1;
    end else if (mode_reg == MODE_ASYNC8) begin
      accept = matchOk && rxEv.stopValid;
    end else begin
      accept = rxEv.ninth && matchOk;
    end
  end

  assign riSet = decide && accept;
  assign feSet = rxEv.stopDone && frameErrEnable_reg && !rxEv.stopValid;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign regIdx = paddr[9:2];
  assign access = psel && penable;
  assign wrDone = access && pready_reg && pwrite && hit;
  assign rdDone = access && pready_reg && !pwrite && hit;
  assign txStart = wrDone && regIdx == IDX_TX_DATA && !txBusy_reg && asyncMode;

  always_comb begin
    hit = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0;
    readMux = '0;
    case (regIdx)
      IDX_SERIAL_CTRL: begin
        readMux[CTL_MODE_LSB +: 2] = mode_reg;
        readMux[CTL_MULTIPROC] = multiproc_reg;
        readMux[CTL_RX_EN] = rxEnable_reg;
        readMux[CTL_TX_NINTH] = txNinth_reg;
        readMux[CTL_RX_NINTH] = rxNinth_reg;
        readMux[CTL_RX_FLAG] = rxFlag_reg;
        readMux[CTL_FE_FLAG] = frameErr_reg;
        readMux[CTL_TX_BUSY] = txBusy_reg;
      end
      IDX_POWER_CTRL: readMux[PWR_FE_EN] = frameErrEnable_reg;
      IDX_RX_DATA: readMux[7:0] = rxData_reg;
      IDX_TX_DATA: readMux = '0;
      IDX_RX_DIV: readMux[DIV_W-1:0] = rxDiv_reg;
      IDX_TX_DIV: readMux[DIV_W-1:0] = txDiv_reg;
      IDX_IRQ_STAT: readMux[IRQ_W-1:0] = irqStat_reg;
      IDX_IRQ_MASK: readMux[IRQ_W-1:0] = irqMask_reg;
      IDX_NODE_ADDR: readMux[7:0] = nodeAddr_reg;
      IDX_NODE_MASK: readMux[7:0] = nodeMask_reg;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= access && !pready_reg;
      pslverr_reg <= access && !pready_reg && !hit;
      prdata_reg <= (access && !pready_reg && !pwrite) ? readMux : '0;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= MODE_SYNC;
      multiproc_reg <= 1'b0;
      rxEnable_reg <= 1'b0;
      txNinth_reg <= 1'b0;
      frameErrEnable_reg <= 1'b0;
      rxDiv_reg <= DIV_RESET;
      txDiv_reg <= DIV_RESET;
      irqMask_reg <= IRQ_MASK_RESET;
      nodeAddr_reg <= ADDR_RESET;
      nodeMask_reg <= MASK_RESET;
    end else if (wrDone) begin
      case (regIdx)
        IDX_SERIAL_CTRL: begin
          mode_reg <= serial_mode_t'(pwdata[CTL_MODE_LSB +: 2]);
          multiproc_reg <= pwdata[CTL_MULTIPROC];
          rxEnable_reg <= pwdata[CTL_RX_EN];
          txNinth_reg <= pwdata[CTL_TX_NINTH];
        end
        IDX_POWER_CTRL: frameErrEnable_reg <= pwdata[PWR_FE_EN];
        IDX_RX_DIV: rxDiv_reg <= pwdata[DIV_W-1:0];
        IDX_TX_DIV: txDiv_reg <= pwdata[DIV_W-1:0];
        IDX_IRQ_MASK: irqMask_reg <= pwdata[IRQ_W-1:0];
        IDX_NODE_ADDR: nodeAddr_reg <= pwdata[7:0];
        IDX_NODE_MASK: nodeMask_reg <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // status flags and received data
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rxFlag_reg <= 1'b0;
      frameErr_reg <= 1'b0;
      rxData_reg <= 8'h00;
      rxNinth_reg <= 1'b0;
    end else begin
      if (wrDone && regIdx == IDX_SERIAL_CTRL) begin
        rxFlag_reg <= pwdata[CTL_RX_FLAG] || riSet;
        frameErr_reg <= pwdata[CTL_FE_FLAG] || feSet;
      end else begin
        rxFlag_reg <= rxFlag_reg || riSet;
        frameErr_reg <= frameErr_reg || feSet;
      end
      if (riSet) begin
        rxData_reg <= rxEv.data;
        rxNinth_reg <= rxEv.ninth;
      end
    end
  end

  // ----------------------------------------
  // interrupt status and output
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irqStat_reg & irqMask_reg);
      if (rdDone && regIdx == IDX_IRQ_STAT) begin
        irqStat_reg <= (irqStat_reg & ~prdata_reg[IRQ_W-1:0]) | {txDone_reg, feSet, riSet};
      end else begin
        irqStat_reg <= irqStat_reg | {txDone_reg, feSet, riSet};
      end
    end
  end

  // ----------------------------------------
  // transmitter, own rate, independent of receiver
  // ----------------------------------------
  assign txBitEnd = txBusy_reg && txCnt_reg == '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      txBusy_reg <= 1'b0;
      txLine_reg <= 1'b1;
      txShift_reg <= 10'h3FF;
      txLeft_reg <= 4'h0;
      txCnt_reg <= '0;
      txDone_reg <= 1'b0;
    end else begin
      txDone_reg <= 1'b0;
      if (txStart) begin
        txBusy_reg <= 1'b1;
        txLine_reg <= 1'b0;
        txCnt_reg <= txDiv_reg - 1'b1;
        if (mode_reg == MODE_ASYNC8) begin
          txShift_reg <= {2'h3, pwdata[7:0]};
          txLeft_reg <= 4'h9;
        end else begin
          txShift_reg <= {1'b1, txNinth_reg, pwdata[7:0]};
          txLeft_reg <= 4'hA;
        end
      end else if (txBitEnd) begin
        if (txLeft_reg == 4'h0) begin
          txBusy_reg <= 1'b0;
          txDone_reg <= 1'b1;
        end else begin
          txLine_reg <= txShift_reg[0];
          txShift_reg <= {1'b1, txShift_reg[9:1]};
          txLeft_reg <= txLeft_reg - 1'b1;
          txCnt_reg <= txDiv_reg - 1'b1;
        end
      end else if (txBusy_reg) begin
        txCnt_reg <= txCnt_reg - 1'b1;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign txLine = txLine_reg;
  assign irq = irq_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_FE_ONLY_ENABLED: assert property (@(posedge clk) disable iff (rst)
    $rose(frameErr_reg) && !$past(wrDone) |-> $past(frameErrEnable_reg) && $past(asyncMode))
    else $error("frame error set while checking disabled");
  AST_FE_ON_BAD_STOP: assert property (@(posedge clk) disable iff (rst)
    rxEv.stopDone && !rxEv.stopValid && frameErrEnable_reg |=> frameErr_reg)
    else $error("bad stop bit did not set frame error");
  AST_FE_STICKY: assert property (@(posedge clk) disable iff (rst)
    frameErr_reg && !(wrDone && regIdx == IDX_SERIAL_CTRL) |=> frameErr_reg)
    else $error("frame error cleared without software write");
  AST_RI_AT_STOP: assert property (@(posedge clk) disable iff (rst)
    $rose(rxFlag_reg) && !$past(wrDone) && $past(frameErrEnable_reg) |-> $past(rxEv.stopDone))
    else $error("receive flag not raised at stop bit");
  AST_ADDR_FILTER: assert property (@(posedge clk) disable iff (rst)
    $rose(rxFlag_reg) && !$past(wrDone) && $past(addrOn) |-> $past(matchOk))
    else $error("receive flag set for foreign address");
  AST_MODE1_STOP: assert property (@(posedge clk) disable iff (rst)
    $rose(rxFlag_reg) && !$past(wrDone) && $past(addrOn && mode_reg == MODE_ASYNC8)
    |-> $past(rxEv.stopDone) && $past(rxEv.stopValid))
    else $error("mode 1 address frame accepted without valid stop");
  AST_MODE0_QUIET: assert property (@(posedge clk) disable iff (rst)
    (mode_reg == MODE_SYNC) [*3] |-> !riSet && !feSet && !rxBusy)
    else $error("receiver active in mode 0");
  AST_GIVEN_MATCH: assert property (@(posedge clk) disable iff (rst)
    (rxEv.data & nodeMask_reg) == (nodeAddr_reg & nodeMask_reg) |-> givenHit && matchOk)
    else $error("given address not recognised");
  AST_BCAST_MATCH: assert property (@(posedge clk) disable iff (rst)
    (rxEv.data | ~(nodeAddr_reg | nodeMask_reg)) == 8'hFF |-> bcastHit && matchOk)
    else $error("broadcast address not recognised");
  AST_MATCH_ONLY: assert property (@(posedge clk) disable iff (rst)
    matchOk |-> (rxEv.data & nodeMask_reg) == (nodeAddr_reg & nodeMask_reg)
    || (rxEv.data & (nodeAddr_reg | nodeMask_reg)) == (nodeAddr_reg | nodeMask_reg))
    else $error("match without given or broadcast hit");
  AST_RESET_ADDR: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> nodeAddr_reg == 8'h00 && nodeMask_reg == 8'h00)
    else $error("address registers not cleared by reset");
  AST_TX_DUPLEX: assert property (@(posedge clk) disable iff (rst)
    txBusy_reg && !txBitEnd && rxBusy |=> txBusy_reg)
    else $error("transmitter stalled by receiver");
  AST_NINTH_REQ: assert property (@(posedge clk) disable iff (rst)
    $rose(rxFlag_reg) && !$past(wrDone) && $past(addrOn && mode_reg != MODE_ASYNC8)
    |-> $past(rxEv.ninth))
    else $error("ninth bit zero frame accepted");
endmodule
`default_nettype wire

// File: verif/uart_line_partner.sv
// serial line partner: master node sending frames, monitor of the transmit pin
`timescale 1ns/1ps
`default_nettype none
module uart_line_partner (
  input wire logic clk,
  output logic rxLine,
  input wire logic txLine,
  output logic inStop
);
  initial begin
    rxLine = 1'b1;
    inStop = 1'b0;
  end

  // ----------------------------------------
  // frame sender
  // ----------------------------------------
  task automatic sendBit(input logic b, input int n);
    rxLine <= b;
    repeat (n) @(posedge clk);
  endtask

  task automatic sendFrame(input logic [7:0] d, input logic nine, input logic ninth,
                           input logic stopBit, input int div);
    int i;
    sendBit(1'b0, div);
    for (i = 0; i < 8; i++) begin
      sendBit(d[i], div);
    end
    if (nine) begin
      sendBit(ninth, div);
    end
    inStop <= 1'b1;
    sendBit(stopBit, div);
    inStop <= 1'b0;
    sendBit(1'b1, 2 * div);
  endtask

  // ----------------------------------------
  // transmit monitor
  // ----------------------------------------
  task automatic recvFrame(input int div, output logic [7:0] d, output logic ok);
    int k;
    k = 0;
    d = 8'h00;
    while (txLine !== 1'b0 && k < 400) begin
      @(posedge clk);
      k++;
    end
    repeat (div / 2) @(posedge clk);
    ok = (k < 400) && (txLine === 1'b0);
    for (k = 0; k < 8; k++) begin
      repeat (div) @(posedge clk);
      d[k] = txLine;
    end
    repeat (div) @(posedge clk);
    ok = ok && (txLine === 1'b1);
  endtask
endmodule
`default_nettype wire

// File: verif/uart_frame_check_addr_match_bench.sv
// bench: register access over APB, serial frames and flag checks
`timescale 1ns/1ps
`default_nettype none
module uart_frame_check_addr_match_bench
  import uart_pkg::*;
;
  `define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin badCount++; \
    $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
  logic clk, rst, psel, penable, pwrite, pready, pslverr, rxLine, txLine, irq, inStop, ok;
  logic [APB_ADDR_W-1:0] paddr;
  logic [APB_DATA_W-1:0] pwdata, prdata, rdData;
  logic rdErr;
  logic [7:0] txd;
  logic [47:0] tbl [9];
  int badCount, nTests, i;

  uart_frame_check_addr_match uart_frame_check_addr_match_inst (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxLine(rxLine),
    .txLine(txLine), .irq(irq));
  uart_line_partner uart_line_partner_inst (.clk(clk), .rxLine(rxLine), .txLine(txLine),
    .inStop(inStop));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      badCount++;
      printVerdict();
    end else begin
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0000_0000);
  endtask

  task automatic frameEarly(input logic [7:0] d, input logic ex);
    int k;
    fork
      uart_line_partner_inst.sendFrame(d, 1'b0, 1'b0, 1'b1, 16);
      begin
        for (k = 0; k < 400 && inStop !== 1'b1; k++) @(posedge clk);
        if (k >= 400) begin
          badCount++;
          printVerdict();
        end
        rd(IDX_SERIAL_CTRL);
        `CHK("early flag", ex, rdData[CTL_RX_FLAG])
      end
    join
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    badCount = 0;
    nTests = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    // ctl, mask, data, ninth, stop, expected flag
    tbl = '{48'h0F_FC_55_01_01_01, 48'h0F_FC_5A_01_01_00, 48'h0E_FC_FE_01_01_01,
            48'h0F_FC_55_00_01_00, 48'h0B_FC_5A_00_01_01, 48'h0D_FC_55_00_00_00,
            48'h0D_FC_55_00_01_01, 48'h0F_FF_57_01_01_00, 48'h0F_FF_56_01_01_01};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(IDX_NODE_ADDR);
    `CHK("node address", 32'h0000_0000, rdData)
    rd(IDX_NODE_MASK);
    `CHK("node mask", 32'h0000_0000, rdData)
    rd(8'h50);
    `CHK("unmapped error", 1'b1, rdErr)
    wr(IDX_RX_DIV, 32'h0000_0010);
    wr(IDX_TX_DIV, 32'h0000_000C);
    wr(IDX_IRQ_MASK, 32'h0000_0001);
    wr(IDX_SERIAL_CTRL, 32'h0000_000C);
    uart_line_partner_inst.sendFrame(8'h3C, 1'b0, 1'b0, 1'b1, 16);
    wr(IDX_TX_DATA, 32'h0000_0081);
    rd(IDX_SERIAL_CTRL);
    `CHK("mode 0 no receive", 1'b0, rdData[CTL_RX_FLAG])
    `CHK("mode 0 no transmit", 1'b0, rdData[CTL_TX_BUSY])
    wr(IDX_SERIAL_CTRL, 32'h0000_000D);
    uart_line_partner_inst.sendFrame(8'h3C, 1'b0, 1'b0, 1'b1, 16);
    `CHK("irq raised", 1'b1, irq)
    rd(IDX_RX_DATA);
    `CHK("rx data any address", 32'h0000_003C, rdData)
    rd(IDX_IRQ_STAT);
    `CHK("irq status", 1'b1, rdData[IRQ_RX])
    @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    wr(IDX_IRQ_MASK, 32'h0000_0000);
    wr(IDX_NODE_ADDR, 32'h0000_0056);
    for (i = 0; i < 9; i++) begin
      wr(IDX_SERIAL_CTRL, {24'h0, tbl[i][47:40]});
      wr(IDX_NODE_MASK, {24'h0, tbl[i][39:32]});
      uart_line_partner_inst.sendFrame(tbl[i][31:24], tbl[i][41], tbl[i][16], tbl[i][8], 16);
      rd(IDX_SERIAL_CTRL);
      `CHK("address filter", tbl[i][0], rdData[CTL_RX_FLAG])
    end
    `CHK("irq masked", 1'b0, irq)
    wr(IDX_SERIAL_CTRL, 32'h0000_0009);
    wr(IDX_POWER_CTRL, 32'h0000_0000);
    frameEarly(8'h11, 1'b1);
    uart_line_partner_inst.sendFrame(8'h22, 1'b0, 1'b0, 1'b0, 16);
    rd(IDX_SERIAL_CTRL);
    `CHK("no check when off", 1'b0, rdData[CTL_FE_FLAG])
    wr(IDX_POWER_CTRL, 32'h0000_0001);
    wr(IDX_SERIAL_CTRL, 32'h0000_0009);
    frameEarly(8'h33, 1'b0);
    uart_line_partner_inst.sendFrame(8'h44, 1'b0, 1'b0, 1'b0, 16);
    rd(IDX_SERIAL_CTRL);
    `CHK("frame error", 1'b1, rdData[CTL_FE_FLAG])
    uart_line_partner_inst.sendFrame(8'h55, 1'b0, 1'b0, 1'b1, 16);
    rd(IDX_SERIAL_CTRL);
    `CHK("frame error sticky", 1'b1, rdData[CTL_FE_FLAG])
    wr(IDX_SERIAL_CTRL, 32'h0000_0009);
    rd(IDX_SERIAL_CTRL);
    `CHK("frame error cleared", 1'b0, rdData[CTL_FE_FLAG])
    fork
      uart_line_partner_inst.sendFrame(8'hA5, 1'b0, 1'b0, 1'b1, 16);
      begin
        wr(IDX_TX_DATA, 32'h0000_00C3);
        uart_line_partner_inst.recvFrame(12, txd, ok);
      end
    join
    rd(IDX_RX_DATA);
    `CHK("duplex rx", 32'h0000_00A5, rdData)
    `CHK("duplex tx", 9'h1C3, ({ok, txd}))
    rd(IDX_IRQ_STAT);
    `CHK("irq status events", 3'h7, rdData[IRQ_W-1:0])
    printVerdict();
  end
endmodule
`default_nettype wire
